// ### async_tick_sync.sv
// Brings a free-running asynchronous conversion clock into clk.
// Assumes the pin clock is well below half the bus clock rate.
`timescale 1ns/10ps
module async_tick_sync (
    input  wire logic clk,      // Bus clock
    input  wire logic rst,      // Async reset, high
    input  wire logic asyncPin, // Foreign clock pin
    output logic      tick      // One pulse per rising edge
);
    // All state in one struct
    typedef struct packed {
        logic meta;   // First stage, read only by the second
        logic stable; // Second stage
        logic last;   // Previous stable level
        logic tick;   // Registered edge pulse
    } sync_state_t;

    sync_state_t s;
    sync_state_t next_s;

    // Shift chain and edge detect on the second stage only
    always_comb begin
        next_s        = s;
        next_s.meta   = asyncPin;
        next_s.stable = s.meta;
        next_s.last   = s.stable;
        next_s.tick   = s.stable & ~s.last;
    end

    // Register the state
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign tick = s.tick;

endmodule : async_tick_sync

// ### conv_ctrl.sv
// Converter control: APB registers, conversion sequencing, coherent
// two-byte result access and the completion interrupt.
// Assumes sampleData is settled in the clk domain by the analog front end
// and that convClkPin is an unrelated clock needing synchronisation.
`timescale 1ns/10ps

module conv_ctrl
    import conv_ctrl_pkg::*;
(
    input  wire logic        clk,           // Bus clock, 25 MHz
    input  wire logic        rst,           // Async reset, high
    input  wire apb_req_t    bus,           // APB request
    output apb_rsp_t         busRsp,        // APB answer
    input  wire logic        convClkPin,    // Asynchronous conversion clock
    input  wire logic [11:0] sampleData,    // Front end output code
    output logic [4:0]       sampleChannel, // Analog mux select
    output logic             convActive,    // Conversion running
    output logic             irq            // Level interrupt
);

    // Whole block state
    typedef struct packed {
        logic [4:0]  channel;    // Selected input
        logic        contMode;   // Continuous conversion
        logic        intEn;      // Completion interrupt enable
        logic        doneFlag;   // conversion_done_flag
        logic [1:0]  resMode;    // Resolution code
        logic        asyncSel;   // Conversion clock source
        logic [11:0] result;     // conversion_result_register
        logic        frozen;     // Low byte held
        logic [7:0]  frozenLow;  // Held low byte
        logic [7:0]  holdLow;    // Low byte seen with a high read
        logic [1:0]  status;     // Sticky events
        logic [1:0]  evEnable;   // Event enables
        conv_state_t conv;       // Activity
        logic [4:0]  tickCount;  // Ticks in this conversion
        apb_rsp_t    rsp;        // Registered bus answer
        logic        irq;        // Registered interrupt
    } ctrl_state_t;

    ctrl_state_t s;
    ctrl_state_t next_s;

    logic asyncTick;   // Synchronised async clock edge
    logic convTick;    // Conversion clock tick this cycle
    logic setupPhase;  // APB setup cycle
    logic accessDone;  // APB access completing at this edge
    logic sc1Write;    // Control register written now
    logic iclrWrite;   // Event clear written now
    logic completeNow; // Conversion finishing now
    logic hiRead;      // High byte read completing now
    logic loRead;      // Low byte read completing now
    logic [1:0] evSet; // Events raised now

    // Foreign clock enters through a two-stage synchroniser
    async_tick_sync u_tick (
        .clk      (clk),
        .rst      (rst),
        .asyncPin (convClkPin),
        .tick     (asyncTick)
    );

    // Scale a raw code to the selected resolution, right justified
    function automatic logic [11:0] scaleCode(input logic [11:0] raw,
                                              input logic [1:0]  mode);
        case (mode)
            RES_8:   scaleCode = {4'h0, raw[11:4]};
            RES_10:  scaleCode = {2'h0, raw[11:2]};
            default: scaleCode = raw;
        endcase
    endfunction : scaleCode

    // Address decode for the error answer; the read mux decodes on its own
    function automatic logic isMapped(input logic [7:0] addr);
        case (addr)
            SC1_OFFSET, CFG_OFFSET, RESH_OFFSET, RESL_OFFSET,
            STAT_OFFSET, IEN_OFFSET, ICLR_OFFSET: isMapped = 1'b1;
            default: isMapped = 1'b0;
        endcase
    endfunction : isMapped

    // Read mux; unused bits read as zero
    function automatic logic [31:0] readValue(input ctrl_state_t st,
                                              input logic [7:0]  addr);
        readValue = 32'h0000_0000;
        case (addr)
            SC1_OFFSET: begin
                readValue[SC1_DONE_BIT] = st.doneFlag;
                readValue[SC1_IEN_BIT]  = st.intEn;
                readValue[SC1_CONT_BIT] = st.contMode;
                readValue[4:0]          = st.channel;
            end
            CFG_OFFSET: begin
                readValue[CFG_ASYNC_BIT] = st.asyncSel;
                readValue[1:0]           = st.resMode;
            end
            // Eight-bit results have no high byte
            RESH_OFFSET: begin
                if (st.resMode != RES_8) begin
                    readValue[3:0] = st.result[11:8];
                end
            end
            RESL_OFFSET: begin
                readValue[7:0] = st.frozen ? st.frozenLow : st.result[7:0];
            end
            STAT_OFFSET: readValue[1:0] = st.status;
            IEN_OFFSET:  readValue[1:0] = st.evEnable;
            default:     readValue = 32'h0000_0000;
        endcase
    endfunction : readValue

    // Bus phase decode; pready is high only in the access cycle
    always_comb begin
        setupPhase = bus.psel & ~bus.penable;
        accessDone = bus.psel & bus.penable & s.rsp.pready;
        sc1Write   = accessDone & bus.pwrite & (bus.paddr == SC1_OFFSET);
        iclrWrite  = accessDone & bus.pwrite & (bus.paddr == ICLR_OFFSET);
        hiRead     = accessDone & ~bus.pwrite & (bus.paddr == RESH_OFFSET);
        loRead     = accessDone & ~bus.pwrite & (bus.paddr == RESL_OFFSET);
    end

    // Conversion timing; the control write wins over a finish
    always_comb begin
        convTick    = s.asyncSel ? asyncTick : 1'b1;
        completeNow = (s.conv == CONV_BUSY) & convTick
                    & (s.tickCount == CONV_TICKS - 5'h01)
                    & ~sc1Write;
        evSet = 2'b00;
        evSet[EV_DONE]   = completeNow;
        evSet[EV_SHIELD] = completeNow & s.frozen;
    end

    // Next state of the whole block
    always_comb begin
        next_s = s;

        // Bus answer: registered in setup, shown in access
        next_s.rsp.pready = setupPhase;
        if (setupPhase) begin
            next_s.rsp.prdata  = readValue(s, bus.paddr);
            next_s.rsp.pslverr = ~isMapped(bus.paddr);
            // Low byte paired with the high byte being returned
            next_s.holdLow = s.result[7:0];
        end

        // Conversion progress
        if (s.conv == CONV_BUSY && convTick) begin
            next_s.tickCount = s.tickCount + 5'h01;
        end
        if (completeNow) begin
            next_s.result   = scaleCode(sampleData, s.resMode);
            next_s.doneFlag = 1'b1;
            next_s.tickCount = 5'h00;
            // Single mode parks until software restarts
            if (!s.contMode) begin
                next_s.conv = CONV_IDLE;
            end
        end

        // Coherent result access, not in eight-bit mode
        if (hiRead && s.resMode != RES_8) begin
            next_s.frozen    = 1'b1;
            next_s.frozenLow = s.holdLow;
        end
        if (loRead) begin
            next_s.frozen = 1'b0;
        end

        // Register writes at the completing access edge
        if (accessDone && bus.pwrite) begin
            case (bus.paddr)
                SC1_OFFSET: begin
                    next_s.channel  = bus.pwdata[4:0];
                    next_s.contMode = bus.pwdata[SC1_CONT_BIT];
                    next_s.intEn    = bus.pwdata[SC1_IEN_BIT];
                    next_s.doneFlag = 1'b0;
                    next_s.tickCount = 5'h00;
                    // Off code stops; any other restarts from zero
                    if (bus.pwdata[4:0] == CHANNEL_OFF) begin
                        next_s.conv = CONV_IDLE;
                    end else begin
                        next_s.conv = CONV_BUSY;
                    end
                end
                CFG_OFFSET: begin
                    next_s.resMode  = bus.pwdata[1:0];
                    next_s.asyncSel = bus.pwdata[CFG_ASYNC_BIT];
                    // A held byte of another width is meaningless
                    next_s.frozen   = 1'b0;
                end
                IEN_OFFSET: next_s.evEnable = bus.pwdata[1:0];
                default: begin
                end
            endcase
        end

        // Sticky events: a set in the clearing cycle survives
        next_s.status = (s.status & ~(iclrWrite ? bus.pwdata[1:0] : 2'b00))
                      | evSet;

        // Interrupt from completion flag or enabled events
        next_s.irq = (next_s.doneFlag & next_s.intEn)
                   | (|(next_s.status & next_s.evEnable));
    end

    // Register the whole state
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            s          <= '0;
            s.channel  <= CHANNEL_RESET;
            s.resMode  <= RES_RESET;
            s.conv     <= CONV_IDLE;
        end else begin
            s <= next_s;
        end
    end

    // Outputs straight from flip-flops
    assign busRsp        = s.rsp;
    assign sampleChannel = s.channel;
    assign convActive    = s.conv[1]; // Busy one-hot bit, no decode
    assign irq           = s.irq;

    // Checks run on the bus clock, quiet during reset
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);

    // Completion loads the scaled code and sets the flag
    property p_done_load;
        completeNow |=> s.doneFlag
            && s.result == scaleCode($past(sampleData), $past(s.resMode));
    endproperty
    a_done_load: assert property (p_done_load)
        else $error("completion did not load result and flag");

    // High byte read in wide mode holds the low byte
    sequence s_hi_wide;
        hiRead && s.resMode != RES_8;
    endsequence
    property p_freeze;
        s_hi_wide |=> s.frozen && s.frozenLow == $past(s.result[7:0], 2);
    endproperty
    a_freeze: assert property (p_freeze)
        else $error("high byte read did not freeze low byte");

    // Completion in the read cycle does not leak into the held byte
    property p_same_cycle;
        s_hi_wide ##0 completeNow
            |=> s.frozenLow == $past(s.result[7:0], 2);
    endproperty
    a_same_cycle: assert property (p_same_cycle)
        else $error("newer low byte leaked into frozen byte");

    // Eight-bit mode never holds a byte
    property p_no_freeze_8;
        s.resMode == RES_8 && $past(s.resMode) == RES_8 |-> !s.frozen;
    endproperty
    a_no_freeze_8: assert property (p_no_freeze_8)
        else $error("freeze in eight-bit mode");

    // Control write always leaves the flag clear
    property p_write_clears;
        sc1Write |=> !s.doneFlag;
    endproperty
    a_write_clears: assert property (p_write_clears)
        else $error("control write left done flag set");

    // Enabled flag shows on the interrupt in the same cycle; both come
    // from one next value, so a clearing write cannot slip between them
    property p_irq;
        s.doneFlag && s.intEn |-> irq;
    endproperty
    a_irq: assert property (p_irq)
        else $error("enabled done flag without interrupt");

    // Off code stops, any channel restarts from tick zero
    property p_channel;
        sc1Write |=> (s.channel == CHANNEL_OFF) ? s.conv == CONV_IDLE
                   : (s.conv == CONV_BUSY && s.tickCount == 5'h00);
    endproperty
    a_channel: assert property (p_channel)
        else $error("control write did not stop or restart");

    // Single mode stays idle after finishing
    property p_single;
        completeNow && !s.contMode ##1 !sc1Write[*2]
            |-> s.conv == CONV_IDLE && $stable(s.result);
    endproperty
    a_single: assert property (p_single)
        else $error("single mode changed result before restart");

    // Async source: progress only on a synchronised edge
    property p_async_hold;
        s.asyncSel && !asyncTick && !sc1Write |=> $stable(s.tickCount);
    endproperty
    a_async_hold: assert property (p_async_hold)
        else $error("conversion advanced without async tick");

    // Completion sets the sticky event even against a clear
    property p_status_set;
        completeNow |=> s.status[EV_DONE];
    endproperty
    a_status_set: assert property (p_status_set)
        else $error("completion did not set the status event");

    // Interrupt only with an enabled cause behind it
    property p_irq_cause;
        irq |-> (s.doneFlag && s.intEn) || (|(s.status & s.evEnable));
    endproperty
    a_irq_cause: assert property (p_irq_cause)
        else $error("interrupt raised without an enabled cause");

    // Completion under a held low byte flags it and keeps it
    property p_shield;
        completeNow && s.frozen && !hiRead
            |=> s.status[EV_SHIELD] && $stable(s.frozenLow);
    endproperty
    a_shield: assert property (p_shield)
        else $error("completion disturbed the held low byte");

    // Bus clock source: one tick every cycle while busy
    property p_bus_clock;
        !s.asyncSel && s.conv == CONV_BUSY && !sc1Write && !completeNow
            |=> s.tickCount == $past(s.tickCount) + 5'h01;
    endproperty
    a_bus_clock: assert property (p_bus_clock)
        else $error("bus clocked conversion did not advance");

    // Eight-bit mode returns no high byte
    property p_eight_zero;
        setupPhase && bus.paddr == RESH_OFFSET && s.resMode == RES_8
            |=> busRsp.prdata == 32'h0000_0000;
    endproperty
    a_eight_zero: assert property (p_eight_zero)
        else $error("high byte read in eight-bit mode not zero");

endmodule : conv_ctrl

// ### conv_ctrl_pkg.sv
// Package for the converter control block: register map, field layout,
// reset values, modes and the APB carrier structs.
// Assumes a 32-bit APB with byte addresses in the low eight bits.
package conv_ctrl_pkg;

    // Register byte offsets
    localparam logic [7:0] SC1_OFFSET  = 8'h00; // conversion_status_control_one
    localparam logic [7:0] CFG_OFFSET  = 8'h04; // resolution and clock source
    localparam logic [7:0] RESH_OFFSET = 8'h08; // result high byte
    localparam logic [7:0] RESL_OFFSET = 8'h0C; // result low byte
    localparam logic [7:0] STAT_OFFSET = 8'h10; // sticky event status
    localparam logic [7:0] IEN_OFFSET  = 8'h14; // event enable
    localparam logic [7:0] ICLR_OFFSET = 8'h18; // event clear, write only

    // Field positions in the control and CFG registers
    localparam int SC1_DONE_BIT = 7;            // conversion_done_flag
    localparam int SC1_IEN_BIT  = 6;            // completion interrupt enable
    localparam int SC1_CONT_BIT = 5;            // continuous mode
    localparam int CFG_ASYNC_BIT = 2;           // async conversion clock

    // Channel code that switches the converter off
    localparam logic [4:0] CHANNEL_OFF = 5'h1F;

    // Resolution codes
    localparam logic [1:0] RES_8  = 2'h0;
    localparam logic [1:0] RES_12 = 2'h1;
    localparam logic [1:0] RES_10 = 2'h2;

    // Conversion clock ticks per conversion
    localparam logic [4:0] CONV_TICKS = 5'h14;

    // Event bits of the status register
    localparam int EV_DONE   = 0;               // conversion complete
    localparam int EV_SHIELD = 1;               // new result while frozen

    // Reset values
    localparam logic [1:0] RES_RESET     = RES_8;
    localparam logic [4:0] CHANNEL_RESET = CHANNEL_OFF;

    // APB request from the master
    typedef struct packed {
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [7:0]  paddr;
        logic [31:0] pwdata;
    } apb_req_t;

    // APB answer to the master
    typedef struct packed {
        logic        pready;
        logic [31:0] prdata;
        logic        pslverr;
    } apb_rsp_t;

    // Converter activity
    typedef enum logic [1:0] {
        CONV_IDLE = 2'b01,
        CONV_BUSY = 2'b10
    } conv_state_t;

endpackage : conv_ctrl_pkg

// ### test_conv_ctrl.sv
// Self-checking bench for the converter control block: APB access,
// result coherency, completion flag, interrupt and conversion clocks.
// Assumes APB answers within 50 cycles and sampleData settled in clk.
`timescale 1ns/10ps
module test_conv_ctrl;
    import conv_ctrl_pkg::*;

    logic        clk;           // Bus clock, 40 ns
    logic        rst;           // Async reset, high
    apb_req_t    bus;           // APB request
    apb_rsp_t    busRsp;        // APB answer
    logic        convClkPin;    // Foreign conversion clock
    logic        asyncRun;      // Foreign clock runs only when used
    logic [11:0] sampleData;    // Front end code
    logic [4:0]  sampleChannel; // Mux select seen
    logic        convActive;    // Conversion running
    logic        irq;           // Level interrupt
    logic        churn;         // New coherent code every cycle
    logic [3:0]  nib;           // Nibble repeated into the code
    logic [11:0] fixedCode;     // Code held while not churning
    logic [31:0] rd;            // Last read data
    logic        err;           // Last error flag
    int          n_errors;      // Mismatches
    int          n_compared;    // Comparisons

    conv_ctrl uut (.clk(clk), .rst(rst), .bus(bus), .busRsp(busRsp),
        .convClkPin(convClkPin), .sampleData(sampleData),
        .sampleChannel(sampleChannel), .convActive(convActive),
        .irq(irq));

    // Bus clock
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    // Foreign clock, phase unrelated; stands still when unused
    initial begin
        convClkPin = 1'b0;
        forever #75 convClkPin = asyncRun ? ~convClkPin : 1'b0;
    end

    // Sole driver of the code: fixed per test, or churning with a low
    // byte that repeats the high nibble, so a torn pair shows
    always @(posedge clk) begin
        nib = 4'($urandom);
        sampleData <= churn ? {nib, nib, nib} : fixedCode;
    end

    // Verdict and end of run
    task automatic wrap_up;
        $display("errors %0d compared %0d", n_errors, n_compared);
        if (n_errors == 0 && n_compared > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : wrap_up

    // Hung wait
    task automatic give_up;
        n_errors++;
        $display("mismatch %0t wait ran out", $time);
        wrap_up();
    endtask : give_up

    // Word result compare
    task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            n_errors++;
            $display("mismatch %0t word %h expected %h", $time, got, exp);
        end
    endtask : chk_word

    // Flag compare
    task automatic chk_bit(input logic got, input logic exp);
        n_compared++;
        if (got !== exp) begin
            n_errors++;
            $display("mismatch %0t flag %b expected %b", $time, got, exp);
        end
    endtask : chk_bit

    // One APB transfer; request held until pready is seen
    task automatic apb(input logic wr, input logic [7:0] addr,
                       input logic [31:0] wdata);
        int i;
        @(posedge clk);
        bus.psel <= 1'b1;
        bus.penable <= 1'b0;
        bus.pwrite <= wr;
        bus.paddr <= addr;
        bus.pwdata <= wdata;
        @(posedge clk);
        bus.penable <= 1'b1;
        for (i = 0; i < 50; i++) begin
            @(posedge clk);
            if (busRsp.pready === 1'b1) break;
        end
        if (i == 50) give_up();
        rd = busRsp.prdata;
        err = busRsp.pslverr;
        bus.psel <= 1'b0;
        bus.penable <= 1'b0;
    endtask : apb

    // Wait for a single conversion to end, bounded
    task automatic wait_idle;
        int i;
        for (i = 0; i < 600; i++) begin
            @(posedge clk);
            if (i > 1 && convActive === 1'b0) break;
        end
        if (i == 600) give_up();
        repeat (2) @(posedge clk);
    endtask : wait_idle

    // Right-justified result for a resolution
    function automatic logic [11:0] expect_res(input logic [1:0] res,
                                               input logic [11:0] code);
        case (res)
            RES_8:   return {4'h0, code[11:4]};
            RES_10:  return {2'h0, code[11:2]};
            default: return code;
        endcase
    endfunction : expect_res

    // Single conversion, then a prompt high/low read pair
    task automatic conv(input logic [1:0] res, input logic asy,
                        input logic ien);
        logic [4:0]  ch;
        logic [11:0] code;
        logic [11:0] e;
        ch = 5'($urandom_range(30));
        code = 12'($urandom);
        e = expect_res(res, code);
        fixedCode <= code;
        asyncRun <= asy;
        apb(1'b1, CFG_OFFSET, {29'h0, asy, res});
        apb(1'b1, SC1_OFFSET, {24'h0, 1'b0, ien, 1'b0, ch});
        wait_idle();
        chk_word(32'(sampleChannel), 32'(ch));
        chk_bit(irq, ien);
        apb(1'b0, RESH_OFFSET, 32'h0);
        chk_word(rd, {28'h0, e[11:8]});
        apb(1'b0, RESL_OFFSET, 32'h0);
        chk_word(rd, {24'h0, e[7:0]});
        apb(1'b0, SC1_OFFSET, 32'h0);
        chk_bit(rd[SC1_DONE_BIT], 1'b1);
    endtask : conv

    // Hang guard
    initial begin
        repeat (100000) @(posedge clk);
        give_up();
    end

    // Main sequence
    initial begin
        int k;
        logic [3:0] h;
        logic [11:0] prevCode;
        rst = 1'b1;
        bus = '0;
        fixedCode = 12'h000;
        asyncRun = 1'b0;
        churn = 1'b0;
        n_errors = 0;
        n_compared = 0;
        void'($urandom(32'h486F));
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        chk_word(32'(sampleChannel), 32'(CHANNEL_OFF));
        chk_bit(convActive, 1'b0);
        chk_bit(irq, 1'b0);
        // Unmapped place answers with an error and zero
        apb(1'b0, 8'h40, 32'h0);
        chk_bit(err, 1'b1);
        chk_word(rd, 32'h0);
        // Every resolution on both clocks, interrupt on and masked
        for (k = 0; k < 6; k++) conv(2'(k % 3), k >= 3, 1'(k % 2));
        // Stop with interrupt off clears the flag
        apb(1'b1, SC1_OFFSET, {27'h0, CHANNEL_OFF});
        apb(1'b0, SC1_OFFSET, 32'h0);
        chk_bit(rd[SC1_DONE_BIT], 1'b0);
        chk_bit(irq, 1'b0);
        // Sticky status through the enable register
        apb(1'b1, IEN_OFFSET, 32'h1);
        apb(1'b0, STAT_OFFSET, 32'h0);
        chk_bit(rd[EV_DONE], 1'b1);
        chk_bit(irq, 1'b1);
        apb(1'b1, ICLR_OFFSET, 32'h3);
        apb(1'b0, STAT_OFFSET, 32'h0);
        chk_word(rd, 32'h0);
        chk_bit(irq, 1'b0);
        apb(1'b1, IEN_OFFSET, 32'h0);
        // Channel rewrite mid-conversion restarts the count
        asyncRun <= 1'b0;
        apb(1'b1, CFG_OFFSET, {30'h0, RES_12});
        apb(1'b1, SC1_OFFSET, 32'h02);
        repeat (10) @(posedge clk);
        apb(1'b1, SC1_OFFSET, 32'h04);
        repeat (15) @(posedge clk);
        chk_bit(convActive, 1'b1);
        wait_idle();
        // Completion while the low byte is held keeps it and flags it
        prevCode = fixedCode;
        apb(1'b0, RESH_OFFSET, 32'h0);
        chk_word(rd, {28'h0, prevCode[11:8]});
        fixedCode <= ~prevCode;
        apb(1'b1, SC1_OFFSET, 32'h05);
        wait_idle();
        apb(1'b0, STAT_OFFSET, 32'h0);
        chk_bit(rd[EV_SHIELD], 1'b1);
        apb(1'b0, RESL_OFFSET, 32'h0);
        chk_word(rd, {24'h0, prevCode[7:0]});
        // Continuous run, reads after waits of 0 to 23 cycles against completions
        churn <= 1'b1;
        apb(1'b1, SC1_OFFSET, 32'h23);
        // First churned result must land before the reads start
        repeat (24) @(posedge clk);
        for (k = 0; k < 48; k++) begin
            repeat (k % 24) @(posedge clk);
            apb(1'b0, RESH_OFFSET, 32'h0);
            h = rd[3:0];
            apb(1'b0, RESL_OFFSET, 32'h0);
            chk_word(rd, {24'h0, h, h});
        end
        apb(1'b1, SC1_OFFSET, {27'h0, CHANNEL_OFF});
        wrap_up();
    end
endmodule : test_conv_ctrl
